// ==== rtl/otp_port_pkg.sv ====
// Constants shared by the PROM programming port ends.
// Assumes both ends compile against this package first.
package otp_port_pkg;
    // ----------------------------------------
    // Store geometry
    // ----------------------------------------
    localparam int WORD_COUNT = 4096;
    localparam int WORD_WIDTH = 16;
    localparam int ADDR_WIDTH = 12;
    localparam int DATA_WIDTH = 8;
    localparam int PULSES_PER_WORD = 4;
    localparam logic [11:0] ADDR_LAST = 12'hFFF;
    localparam logic [11:0] ADDR_RESET = 12'h000;
    localparam logic [1:0] SUB_RESET = 2'h0;
    // ----------------------------------------
    // Mode select patterns, bit 0 is select pin 0
    // ----------------------------------------
    localparam logic [3:0] MODE_CLEAR = 4'h5;
    localparam logic [3:0] MODE_WRITE = 4'hE;
    localparam logic [3:0] MODE_VERIFY = 4'hC;
    localparam logic [3:0] MODE_INHIBIT_MASK = 4'hD;
    localparam logic [3:0] MODE_INHIBIT = 4'hD;
    // ----------------------------------------
    // Programmer timing at 200 MHz
    // ----------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SUPPLY_WAIT_US = 10;
    localparam int SUPPLY_WAIT_CYCLES = (SUPPLY_WAIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WRITE_PULSE_MS = 1;
    localparam int WRITE_PULSE_CYCLES = (WRITE_PULSE_MS * 1000000000) / CLK_PERIOD_PS;
    localparam int LINK_DIV = 8;
    localparam int MAX_RETRIES = 25;
endpackage : otp_port_pkg

// ==== rtl/otp_link_if.sv ====
// Pins between the PROM port and its programmer.
// Assumes the bench resolves the data bus from the two enables.
`timescale 1ns/1ps
interface otp_link_if;
    logic link_clk;
    logic [3:0] prog_mode_select;
    logic programming_supply;
    logic normal_supply;
    logic reset_n;
    logic [7:0] data_to_dev;
    logic data_to_dev_oe;
    logic [7:0] data_from_dev;
    logic data_from_dev_oe;
    modport device (input link_clk, input prog_mode_select, input programming_supply, input normal_supply,
        input reset_n, input data_to_dev, input data_to_dev_oe, output data_from_dev, output data_from_dev_oe);
    modport programmer (output link_clk, output prog_mode_select, output programming_supply,
        output normal_supply, output reset_n, output data_to_dev, output data_to_dev_oe,
        input data_from_dev, input data_from_dev_oe);
endinterface : otp_link_if

// ==== rtl/otp_prom_port.sv ====
// Device end: the one-time PROM store and its address-clocked access.
// Assumes the link clock is the address-update clock from the programmer.
`timescale 1ns/1ps
module otp_prom_port
    import otp_port_pkg::*;
#(
    parameter int WORDS = WORD_COUNT
)
(
    // Link
    otp_link_if.device LINK,
    // Status
    output logic PROG_MODE,
    output logic [otp_port_pkg::ADDR_WIDTH-1:0] ADDR
);
    import otp_port_pkg::*;
    // ----------------------------------------
    // Store and counters
    // ----------------------------------------
    logic [WORD_WIDTH-1:0] store_mem [0:WORDS-1];
    logic [ADDR_WIDTH-1:0] program_address_counter;
    logic [1:0] sub_reg;
    logic armed_reg;
    logic prog_reg;
    logic prog_now;
    logic [3:0] mode;
    logic [7:0] out_reg;
    logic oe_reg;
    assign mode = LINK.prog_mode_select;
    // Supplies and mode move only while the link clock is idle, so they are read directly
    assign prog_now = armed_reg && LINK.programming_supply;

    // Armed when the programming supply rises while reset is held low
    always_ff @(posedge LINK.programming_supply or negedge LINK.normal_supply)
    begin
        if (!LINK.normal_supply)
            armed_reg <= 1'b0;
        else
            armed_reg <= !LINK.reset_n;
    end

    // Status copy of the entry condition, dropped with normal supply
    always_ff @(posedge LINK.link_clk or negedge LINK.normal_supply)
    begin
        if (!LINK.normal_supply)
            prog_reg <= 1'b0;
        else
            prog_reg <= prog_now;
    end

    // Address counter, four pulses per word, no address pins
    always_ff @(posedge LINK.link_clk or negedge LINK.normal_supply)
    begin
        if (!LINK.normal_supply)
        begin
            program_address_counter <= ADDR_RESET;
            sub_reg <= SUB_RESET;
        end
        else if (prog_now && mode == MODE_CLEAR)
        begin
            program_address_counter <= ADDR_RESET;
            sub_reg <= SUB_RESET;
        end
        else if (prog_now && mode == MODE_WRITE)
            // Write pulses only pick the lane, so a retry rewrites the same word
            sub_reg <= {1'b0, ~sub_reg[0]};
        else if (prog_now)
        begin
            sub_reg <= sub_reg + 2'h1;
            if (sub_reg == 2'h3)
                program_address_counter <= program_address_counter + 12'h001;
        end
    end

    // Write: lane 0 carries the low byte, lane 1 the high byte
    always_ff @(posedge LINK.link_clk)
    begin
        if (prog_now && mode == MODE_WRITE && LINK.data_to_dev_oe)
        begin
            if (sub_reg[0])
                store_mem[program_address_counter][15:8] <= LINK.data_to_dev;
            else
                store_mem[program_address_counter][7:0] <= LINK.data_to_dev;
        end
    end

    // Verify drives the bus; inhibit and other patterns release it
    always_ff @(posedge LINK.link_clk or negedge LINK.normal_supply)
    begin
        if (!LINK.normal_supply)
        begin
            out_reg <= 8'h00;
            oe_reg <= 1'b0;
        end
        else
        begin
            oe_reg <= prog_now && mode == MODE_VERIFY;
            out_reg <= sub_reg[0] ? store_mem[program_address_counter][15:8]
                                  : store_mem[program_address_counter][7:0];
        end
    end

    assign LINK.data_from_dev = out_reg;
    // Released as soon as verify ends, before the programmer can drive again
    assign LINK.data_from_dev_oe = oe_reg && mode == MODE_VERIFY;
    assign PROG_MODE = prog_reg;
    assign ADDR = program_address_counter;
endmodule : otp_prom_port

// ==== rtl/otp_programmer.sv ====
// Programmer end: writes, verifies and reads the PROM over the link.
// Assumes a plain register port from software on CLK; link clock is derived here.
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module otp_programmer
    import otp_port_pkg::*;
#(
    parameter int PULSE_CYCLES = WRITE_PULSE_CYCLES
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // Register port
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    // Link
    otp_link_if.programmer LINK
);
    import otp_port_pkg::*;
    // ----------------------------------------
    // Register map (word index)
    // ----------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_DATA = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam logic [3:0] REG_READ = 4'h3;

    typedef enum logic [3:0]
    {
        ST_IDLE = 4'h0, ST_POWER = 4'h1, ST_CLEAR = 4'h3, ST_INHIBIT = 4'h2,
        ST_WRITE = 4'h6, ST_WINH = 4'h7, ST_VERIFY = 4'h5, ST_EXTRA = 4'h4,
        ST_NEXT = 4'hC, ST_DONE = 4'hD, ST_OFF = 4'hF, ST_STEP = 4'hA
    } state_t;

    state_t state_reg;
    logic [31:0] timer_reg;
    logic [7:0] retry_reg;
    logic [1:0] pulse_reg;
    logic [2:0] div_reg;
    logic lclk_reg;
    logic [15:0] wdata_reg;
    logic [15:0] rword_reg;
    logic [11:0] addr_reg;
    logic [11:0] last_reg;
    logic read_only_reg;
    logic fail_reg;
    logic busy_reg;
    logic [3:0] mode_reg;
    logic vpp_reg;
    logic vdd_reg;
    logic rst_reg;
    logic [7:0] din_s1_reg;
    logic [7:0] din_s2_reg;
    logic start;
    logic pulse_done;
    assign start = WR && ADDR == REG_CTRL && WDATA[0] && !busy_reg;
    // Marks the end of each link pulse, on the last divider count of its high phase
    assign pulse_done = div_reg == 3'(LINK_DIV - 1) && lclk_reg;

    // ----------------------------------------
    // Session sequencer
    // ----------------------------------------
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state_reg <= ST_IDLE;
            timer_reg <= 32'h0;
            retry_reg <= 8'h00;
            pulse_reg <= 2'h0;
            mode_reg <= MODE_INHIBIT;
            vpp_reg <= 1'b0;
            vdd_reg <= 1'b0;
            rst_reg <= 1'b0;
            busy_reg <= 1'b0;
            fail_reg <= 1'b0;
            addr_reg <= ADDR_RESET;
            rword_reg <= 16'h0000;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        busy_reg <= 1'b1;
                        fail_reg <= 1'b0;
                        vdd_reg <= 1'b1;
                        rst_reg <= 1'b0;
                        vpp_reg <= 1'b0;
                        mode_reg <= MODE_CLEAR;
                        timer_reg <= 32'(SUPPLY_WAIT_CYCLES);
                        addr_reg <= ADDR_RESET;
                        pulse_reg <= 2'h0;
                        state_reg <= ST_POWER;
                    end
                end
                ST_POWER:
                begin
                    if (timer_reg != 32'h0)
                        timer_reg <= timer_reg - 32'h1;
                    else
                    begin
                        vpp_reg <= 1'b1;
                        timer_reg <= 32'(SUPPLY_WAIT_CYCLES);
                        state_reg <= ST_CLEAR;
                    end
                end
                ST_CLEAR:
                begin
                    // One pulse in clear mode zeroes the device counter
                    if (pulse_done)
                        pulse_reg <= pulse_reg + 2'h1;
                    if (timer_reg != 32'h0)
                        timer_reg <= timer_reg - 32'h1;
                    else
                    begin
                        mode_reg <= MODE_INHIBIT;
                        pulse_reg <= 2'h0;
                        retry_reg <= 8'h00;
                        state_reg <= ST_INHIBIT;
                    end
                end
                ST_INHIBIT:
                begin
                    pulse_reg <= 2'h0;
                    if (read_only_reg)
                    begin
                        mode_reg <= MODE_VERIFY;
                        state_reg <= ST_VERIFY;
                    end
                    else if (addr_reg != last_reg)
                        state_reg <= ST_STEP;
                    else
                    begin
                        // One cycle short, so write mode stands exactly one pulse time
                        timer_reg <= 32'(PULSE_CYCLES) - 32'h1;
                        mode_reg <= MODE_WRITE;
                        retry_reg <= retry_reg + 8'h01;
                        state_reg <= ST_WRITE;
                    end
                end
                ST_STEP:
                begin
                    // Words ahead of the target are passed in inhibit mode and left blank
                    if (pulse_done)
                    begin
                        pulse_reg <= pulse_reg + 2'h1;
                        if (pulse_reg == 2'h3)
                        begin
                            addr_reg <= addr_reg + 12'h001;
                            state_reg <= ST_INHIBIT;
                        end
                    end
                end
                ST_WRITE, ST_EXTRA:
                begin
                    // Two link pulses carry the low and then the high byte
                    if (pulse_done)
                        pulse_reg <= pulse_reg + 2'h1;
                    if (timer_reg != 32'h0)
                        timer_reg <= timer_reg - 32'h1;
                    else
                    begin
                        mode_reg <= MODE_INHIBIT;
                        state_reg <= state_reg == ST_WRITE ? ST_WINH : ST_NEXT;
                    end
                end
                ST_WINH:
                begin
                    mode_reg <= MODE_VERIFY;
                    pulse_reg <= 2'h0;
                    state_reg <= ST_VERIFY;
                end
                ST_VERIFY:
                begin
                    if (pulse_done)
                    begin
                        pulse_reg <= pulse_reg + 2'h1;
                        if (pulse_reg[0])
                            rword_reg[15:8] <= din_s2_reg;
                        else
                            rword_reg[7:0] <= din_s2_reg;
                        // A write session checks one word in two pulses; the read walk takes four
                        if (pulse_reg == 2'h3 || (!read_only_reg && pulse_reg == 2'h1))
                        begin
                            pulse_reg <= 2'h0;
                            mode_reg <= MODE_INHIBIT;
                            if (read_only_reg)
                                state_reg <= ST_NEXT;
                            else if ({din_s2_reg, rword_reg[7:0]} == wdata_reg)
                            begin
                                // Extra write lasts retries times one pulse
                                timer_reg <= 32'(PULSE_CYCLES) * {24'h0, retry_reg} - 32'h1;
                                mode_reg <= MODE_WRITE;
                                state_reg <= ST_EXTRA;
                            end
                            else if (retry_reg == 8'(MAX_RETRIES))
                            begin
                                fail_reg <= 1'b1;
                                state_reg <= ST_DONE;
                            end
                            else
                                state_reg <= ST_INHIBIT;
                        end
                    end
                end
                ST_NEXT:
                begin
                    // Four verify pulses of the read walk have already moved the device counter
                    if (addr_reg == last_reg)
                        state_reg <= ST_DONE;
                    else
                    begin
                        addr_reg <= addr_reg + 12'h001;
                        retry_reg <= 8'h00;
                        state_reg <= ST_INHIBIT;
                    end
                end
                ST_DONE:
                begin
                    mode_reg <= MODE_CLEAR;
                    vpp_reg <= 1'b0;
                    state_reg <= ST_OFF;
                end
                ST_OFF:
                begin
                    vdd_reg <= 1'b0;
                    busy_reg <= 1'b0;
                    state_reg <= ST_IDLE;
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Link clock divider, idle low
    // ----------------------------------------
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            div_reg <= 3'h0;
            lclk_reg <= 1'b0;
        end
        else if (((state_reg == ST_WRITE || state_reg == ST_EXTRA) && pulse_reg < 2'h2
                  && timer_reg > 32'(LINK_DIV * 8))
                 || (state_reg == ST_CLEAR && pulse_reg == 2'h0 && timer_reg > 32'(LINK_DIV * 8))
                 || state_reg == ST_VERIFY || state_reg == ST_STEP || lclk_reg)
        begin
            div_reg <= div_reg + 3'h1;
            if (div_reg == 3'(LINK_DIV - 1))
                lclk_reg <= ~lclk_reg;
        end
        else
            div_reg <= 3'h0;
    end

    // ----------------------------------------
    // Register port and data pins
    // ----------------------------------------
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            wdata_reg <= 16'h0000;
            last_reg <= ADDR_LAST;
            read_only_reg <= 1'b0;
            RDATA <= 16'h0000;
        end
        else
        begin
            if (WR && ADDR == REG_DATA)
                wdata_reg <= WDATA;
            if (WR && ADDR == REG_CTRL && !busy_reg)
            begin
                read_only_reg <= WDATA[1];
                last_reg <= WDATA[15:4];
            end
            if (RD)
            begin
                case (ADDR)
                    REG_CTRL: RDATA <= {last_reg, 2'h0, read_only_reg, busy_reg};
                    REG_DATA: RDATA <= wdata_reg;
                    REG_STATUS: RDATA <= {addr_reg, state_reg == ST_VERIFY, fail_reg, 1'b0, busy_reg};
                    REG_READ: RDATA <= rword_reg;
                    default: RDATA <= 16'h0000;
                endcase
            end
            else
                RDATA <= 16'h0000;
        end
    end

    // Device data crosses from the link domain
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            din_s1_reg <= 8'h00;
            din_s2_reg <= 8'h00;
        end
        else
        begin
            din_s1_reg <= LINK.data_from_dev;
            din_s2_reg <= din_s1_reg;
        end
    end

    assign LINK.link_clk = lclk_reg;
    assign LINK.prog_mode_select = mode_reg;
    assign LINK.programming_supply = vpp_reg;
    assign LINK.normal_supply = vdd_reg;
    assign LINK.reset_n = rst_reg;
    assign LINK.data_to_dev = pulse_reg[0] ? wdata_reg[15:8] : wdata_reg[7:0];
    assign LINK.data_to_dev_oe = mode_reg == MODE_WRITE;
endmodule : otp_programmer

// ==== verif/otp_link_monitor.sv ====
// Concurrent checks on the link between the PROM port and its programmer.
// Assumes CLK clocks the programmer and the link clock is derived from it.
`timescale 1ns/1ps
module otp_link_monitor
    import otp_port_pkg::*;
#(
    parameter int PULSE_CYCLES = WRITE_PULSE_CYCLES
)
(
    // Programmer clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // Link
    input wire logic link_clk,
    input wire logic [3:0] prog_mode_select,
    input wire logic programming_supply,
    input wire logic normal_supply,
    input wire logic data_to_dev_oe,
    input wire logic data_from_dev_oe,
    // Device status
    input wire logic PROG_MODE
);
    import otp_port_pkg::*;
    logic [15:0] vdd_cycles_reg;
    logic [31:0] write_cycles_reg;
    logic write_sel;

    assign write_sel = (prog_mode_select == MODE_WRITE);

    // ----------------------------------------
    // Helper counters
    // ----------------------------------------
    // Saturates so a long session cannot wrap back under the wait
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            vdd_cycles_reg <= 16'h0000;
        else if (!normal_supply)
            vdd_cycles_reg <= 16'h0000;
        else if (vdd_cycles_reg != 16'hFFFF)
            vdd_cycles_reg <= vdd_cycles_reg + 16'h0001;
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            write_cycles_reg <= 32'h0;
        else if (write_sel)
            write_cycles_reg <= write_cycles_reg + 32'h1;
        else
            write_cycles_reg <= 32'h0;
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    a_bus_no_contention: assert property (!(data_to_dev_oe && data_from_dev_oe))
        else $error("both ends drive the data bus");
    a_write_oe_mode: assert property (data_to_dev_oe |-> write_sel)
        else $error("programmer drives data outside write mode");
    a_verify_oe_rise: assert property ($rose(data_from_dev_oe) |-> prog_mode_select == MODE_VERIFY)
        else $error("device drives data outside verify mode");
    a_mode_legal: assert property (programming_supply |-> (prog_mode_select == MODE_CLEAR) || write_sel
        || (prog_mode_select == MODE_VERIFY) || ((prog_mode_select & MODE_INHIBIT_MASK) == MODE_INHIBIT))
        else $error("undefined mode pattern while powered");
    a_entry_supplies: assert property ($rose(PROG_MODE) |-> programming_supply && normal_supply)
        else $error("programming mode entered without supplies");
    a_power_drop_exit: assert property (!normal_supply |-> !PROG_MODE)
        else $error("programming mode held without supply");
    a_supply_wait: assert property ($rose(programming_supply) |-> vdd_cycles_reg >= SUPPLY_WAIT_CYCLES)
        else $error("programming supply raised too early");
    a_write_pulse_len: assert property ($fell(write_sel) |-> write_cycles_reg != 32'h0
        && (write_cycles_reg % PULSE_CYCLES) == 0)
        else $error("write pulse not a whole number of pulse times");
    a_write_powered: assert property (write_sel |-> programming_supply && normal_supply)
        else $error("write mode without supplies");
    a_vpp_fall_clear: assert property ($fell(programming_supply) |-> prog_mode_select == MODE_CLEAR)
        else $error("programming supply lowered outside clear mode");
    a_idle_when_off: assert property (!normal_supply |-> !link_clk && !programming_supply)
        else $error("link clock or programming supply up without power");

    cover property ($fell(prog_mode_select == MODE_VERIFY));
    cover property ($rose(PROG_MODE));
    cover property ($fell(programming_supply));
endmodule : otp_link_monitor

// ==== verif/otp_program_memory_port_tb_top.sv ====
// Bench joining programmer and PROM port; writes words, reads them back.
// Assumes the register map CTRL 0, DATA 1, STATUS 2, READ 3 of the programmer.
`timescale 1ns/1ps
module otp_program_memory_port_tb_top;
    import otp_port_pkg::*;
    localparam int PULSE = 200;
    localparam int LIMIT = 80000;

    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic prog_mode;
    logic [11:0] dev_addr;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;

    always #2.5 clk = ~clk;

    otp_link_if link_if();
    otp_programmer #(.PULSE_CYCLES(PULSE)) otp_programmer_inst (.CLK(clk), .RESETN(resetn), .ADDR(reg_addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .LINK(link_if));
    otp_prom_port otp_prom_port_inst (.LINK(link_if), .PROG_MODE(prog_mode), .ADDR(dev_addr));
    otp_link_monitor #(.PULSE_CYCLES(PULSE)) otp_link_monitor_inst (.CLK(clk), .RESETN(resetn),
        .link_clk(link_if.link_clk), .prog_mode_select(link_if.prog_mode_select),
        .programming_supply(link_if.programming_supply), .normal_supply(link_if.normal_supply),
        .data_to_dev_oe(link_if.data_to_dev_oe), .data_from_dev_oe(link_if.data_from_dev_oe),
        .PROG_MODE(prog_mode));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic finish_test;
        if (miscompares == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask : check

    task automatic reg_wr(input logic [3:0] idx, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        reg_addr <= idx;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] idx, output logic [15:0] d);
        @(posedge clk);
        rd <= 1'b1;
        reg_addr <= idx;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : reg_rd

    task automatic wait_idle;
        logic [15:0] s;
        int n;
        s = 16'h0001;
        n = 0;
        while (s[0] !== 1'b0 && n < 30000)
        begin
            reg_rd(4'h2, s);
            n++;
        end
        check({15'h0, s[0]}, 16'h0000);
    endtask : wait_idle

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        check({15'h0, link_if.programming_supply}, 16'h0000);
        check({15'h0, link_if.link_clk}, 16'h0000);
        check({12'h0, link_if.prog_mode_select}, {12'h0, MODE_INHIBIT});
        check({4'h0, dev_addr}, {4'h0, ADDR_RESET});
        check({15'h0, prog_mode}, 16'h0000);
        check(rdata, 16'h0000);
    endtask : t_reset

    task automatic t_unmapped;
        logic [15:0] s;
        for (int i = 4; i < 16; i++)
        begin
            reg_rd(i[3:0], s);
            check(s, 16'h0000);
        end
    endtask : t_unmapped

    // Each word goes to its own place once, as a one-time store allows
    task automatic t_write_word(input logic [11:0] a, input logic [15:0] d);
        logic [15:0] s;
        reg_wr(4'h1, d);
        reg_wr(4'h0, {a, 4'h1});
        reg_rd(4'h2, s);
        check({15'h0, s[0]}, 16'h0001);
        wait_idle();
        reg_rd(4'h2, s);
        check({15'h0, s[2]}, 16'h0000);
        check({4'h0, dev_addr}, {4'h0, ADDR_RESET});
        check({15'h0, prog_mode}, 16'h0000);
    endtask : t_write_word

    task automatic t_read_word(input logic [11:0] a, input logic [15:0] exp);
        logic [15:0] s;
        reg_wr(4'h0, {a, 4'h3});
        wait_idle();
        reg_rd(4'h3, s);
        check(s, exp);
        check({4'h0, dev_addr}, {4'h0, ADDR_RESET});
    endtask : t_read_word

    // ----------------------------------------
    // Timeout and main sequence
    // ----------------------------------------
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            miscompares++;
            finish_test();
        end
    end

    initial
    begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        t_reset();
        t_unmapped();
        t_write_word(12'h000, 16'hA53C);
        t_write_word(12'h001, 16'h5AC3);
        t_write_word(12'h002, 16'h0FF0);
        t_read_word(12'h002, 16'h0FF0);
        t_read_word(12'h000, 16'hA53C);
        t_read_word(12'h001, 16'h5AC3);
        finish_test();
    end
endmodule : otp_program_memory_port_tb_top
